//--- verilog/crs_cfg.svh
// constants for the core register set: bit positions, reset values, stack steps
`ifndef CRS_CFG_SVH
`define CRS_CFG_SVH

// ----------------------------------------------------------------
// register indices
// ----------------------------------------------------------------
`define CRS_IDX_PROG      4'h0
`define CRS_IDX_STACK     4'h1
`define CRS_IDX_STATUS    4'h2
`define CRS_IDX_CONST     4'h3
`define CRS_IDX_GPR_LO    4'h4

// ----------------------------------------------------------------
// status word bit positions
// ----------------------------------------------------------------
`define CRS_BIT_CARRY     0
`define CRS_BIT_ZERO      1
`define CRS_BIT_NEG       2
`define CRS_BIT_IRQ_EN    3
`define CRS_BIT_HALT      4
`define CRS_BIT_OSC_STOP  5
`define CRS_BIT_CG_LOW    6
`define CRS_BIT_CG_HIGH   7
`define CRS_BIT_OVFL      8
`define CRS_STATUS_MASK   16'h01ff

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define CRS_PROG_RST      20'h00000
`define CRS_STACK_RST     20'h00000
`define CRS_STATUS_RST    16'h0000
`define CRS_GPR_RST       20'h00000

// ----------------------------------------------------------------
// stack and vector constants
// ----------------------------------------------------------------
`define CRS_STACK_STEP    20'h00002
`define CRS_VEC_TOP       16'hfffe
`define CRS_LEN_BASE      4'h2

`endif

//--- verilog/crs_pkg.sv
// types shared by the core register set
package crs_pkg;

  // ----------------------------------------------------------------
  // command codes
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    OP_NONE                  = 4'h0,
    OP_ADVANCE               = 4'h1,
    OP_WRITE                 = 4'h2,
    OP_FLAGS                 = 4'h3,
    OP_NEAR_JUMP_INSTR       = 4'h4,
    OP_FAR_JUMP_INSTR        = 4'h5,
    OP_NEAR_CALL             = 4'h6,
    OP_FAR_SUBROUTINE_ENTRY  = 4'h7,
    OP_NEAR_RETURN           = 4'h8,
    OP_FAR_SUBROUTINE_EXIT   = 4'h9,
    OP_INTERRUPT_EXIT_INSTR  = 4'ha
  } crs_op_e;

  // ----------------------------------------------------------------
  // operand sizes
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    SZ_BYTE = 2'h0,
    SZ_WORD = 2'h1,
    SZ_ADDR = 2'h2
  } crs_size_e;

  // ----------------------------------------------------------------
  // sequencer states, gray along push, read, wait, take
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_PUSH = 3'h1,
    ST_READ = 3'h3,
    ST_WAIT = 3'h2,
    ST_TAKE = 3'h6
  } crs_state_e;

endpackage

//--- verilog/crs_flag_unit.sv
// adder and flag generation for byte and word operations
`timescale 1ns/10ps
`default_nettype none

module crs_flag_unit (
  input  wire logic        [15:0] opnd_a,
  input  wire logic        [15:0] opnd_b,
  input  wire logic               do_sub,
  input  wire logic               byte_mode,
  output logic             [15:0] result,
  output logic                    carry,
  output logic                    zero,
  output logic                    negative,
  output logic                    overflow
);

  logic [15:0] b_inv;
  logic [16:0] sum_w;
  logic [8:0]  sum_b;
  logic        msb_a;
  logic        msb_b;
  logic        msb_r;

  // ----------------------------------------------------------------
  // sum and flags
  // ----------------------------------------------------------------
  always_comb begin
    b_inv    = do_sub ? ~opnd_b : opnd_b;
    sum_w    = {1'b0, opnd_a} + {1'b0, b_inv} + {16'h0000, do_sub};
    sum_b    = {1'b0, opnd_a[7:0]} + {1'b0, b_inv[7:0]} + {8'h00, do_sub};
    result   = byte_mode ? {8'h00, sum_b[7:0]} : sum_w[15:0];
    carry    = byte_mode ? sum_b[8] : sum_w[16];                 // see RL20
    msb_a    = byte_mode ? opnd_a[7] : opnd_a[15];
    msb_b    = byte_mode ? opnd_b[7] : opnd_b[15];
    msb_r    = byte_mode ? result[7] : result[15];
    zero     = (result == 16'h0000);                             // see RL20
    negative = msb_r;                                            // see RL20
    if (do_sub) begin
      overflow = (msb_a != msb_b) && (msb_r != msb_a);           // see RL19
    end else begin
      overflow = (msb_a == msb_b) && (msb_r != msb_a);           // see RL19
    end
  end

endmodule

`default_nettype wire

//--- verilog/crs_core_regs.sv
// dedicated core registers, working registers and call/return/interrupt stacking
`timescale 1ns/10ps
`default_nettype none
`include "crs_cfg.svh"

// What this block does
// RL1: full 20-bit addresses, no paging
// RL2: vector table downward from top word
// RL3: vectors hold 16-bit handler addresses
// RL4: interrupt pushes counter and status with bits 19:16
// RL5: interrupt return restores all 20 counter bits
// RL6: sixteen registers, four dedicated, twelve general
// RL7: counter advances by even length 2..8
// RL8: counter bit zero always zero
// RL9: near jump and call clear upper bits
// RL10: far jump and call load 20 bits
// RL11: word write to counter clears upper bits
// RL12: near call pushes 16 bits, far 20
// RL13: far return reloads 20 bits, stack +4
// RL14: near return reloads 16 bits, stack +2
// RL15: stack predecrement on push, postincrement on pop
// RL16: stack pointer always even, software initialises
// RL17: status written only word register mode
// RL18: software must not write 20-bit status
// RL19: overflow on signed add/subtract sign violation
// RL20: zero, negative, carry follow result
// RL21: global enable gates maskable interrupts
// RL22: halt bit halts, oscillator stop when unused
// RL23: status bit layout, upper bits reserved
// RL24: interrupt entry drops stack four, clears enable
module crs_core_regs (
  input  wire logic                clk_sys,
  input  wire logic                rst,
  input  wire logic                cmd_valid,
  input  wire crs_pkg::crs_op_e    cmd_op,
  input  wire logic        [3:0]   cmd_idx,
  input  wire crs_pkg::crs_size_e  cmd_size,
  input  wire logic                cmd_reg_mode,
  input  wire logic        [19:0]  cmd_data,
  input  wire logic        [15:0]  cmd_opnd_b,
  input  wire logic                cmd_sub,
  input  wire logic                cmd_wr_back,
  input  wire logic        [1:0]   cmd_len,
  input  wire logic                irq_req,
  input  wire logic                irq_nmi,
  input  wire logic        [4:0]   irq_num,
  input  wire logic                lf_xtal_in_use,
  input  wire logic        [3:0]   rd_idx,
  input  wire logic        [15:0]  mem_rdata,
  output logic                     cmd_ready_r,
  output logic                     cmd_ack_r,
  output logic                     irq_ack_r,
  output logic             [19:0]  prog_cnt_r,
  output logic             [19:0]  stk_ptr_r,
  output logic             [15:0]  status_r,
  output logic             [19:0]  rd_data_r,
  output logic             [19:0]  mem_addr_r,
  output logic             [15:0]  mem_wdata_r,
  output logic                     mem_wr_r,
  output logic                     mem_rd_r,
  output logic                     cpu_halt_r,
  output logic                     osc_stop_r
);

  crs_pkg::crs_state_e state_r;
  crs_pkg::crs_state_e state_nxt;
  crs_pkg::crs_op_e    op_r;
  logic                irq_seq_r;
  logic        [1:0]   wcnt_r;
  logic        [1:0]   rcnt_r;
  logic        [15:0]  word0_r;
  logic        [15:0]  word1_r;
  logic        [15:0]  rd0_r;
  logic        [15:0]  vec_addr_r;
  logic        [19:0]  gpr_r [4:15];
  logic                irq_take;
  logic                cmd_go;
  logic                take_last;
  logic        [15:0]  flag_res;
  logic                flag_c;
  logic                flag_z;
  logic                flag_n;
  logic                flag_v;
  logic        [19:0]  wr_fit;
  logic        [19:0]  res_fit;
  logic        [19:0]  step_bytes;
  logic                gpr_hit;

  // ----------------------------------------------------------------
  // size handling of a register write
  // ----------------------------------------------------------------
  function automatic logic [19:0] fit_size(input logic [19:0] d, input crs_pkg::crs_size_e sz);
    logic [19:0] v;
    unique case (sz)
      crs_pkg::SZ_BYTE: v = {12'h000, d[7:0]};
      crs_pkg::SZ_WORD: v = {4'h0, d[15:0]};
      crs_pkg::SZ_ADDR: v = d;
      default:          v = {4'h0, d[15:0]};
    endcase
    return v;
  endfunction

  // ----------------------------------------------------------------
  // adder and flags
  // ----------------------------------------------------------------
  crs_flag_unit u_flag (
    .opnd_a    (cmd_data[15:0]),
    .opnd_b    (cmd_opnd_b),
    .do_sub    (cmd_sub),
    .byte_mode (cmd_size == crs_pkg::SZ_BYTE),
    .result    (flag_res),
    .carry     (flag_c),
    .zero      (flag_z),
    .negative  (flag_n),
    .overflow  (flag_v)
  );

  // ----------------------------------------------------------------
  // acceptance and shared terms
  // ----------------------------------------------------------------
  always_comb begin
    irq_take   = (state_r == crs_pkg::ST_IDLE) && irq_req
                 && (status_r[`CRS_BIT_IRQ_EN] || irq_nmi);          // see RL21
    cmd_go     = (state_r == crs_pkg::ST_IDLE) && cmd_valid && !irq_take
                 && !status_r[`CRS_BIT_HALT];                         // see RL22
    take_last  = (state_r == crs_pkg::ST_TAKE) && (rcnt_r == 2'h1);
    wr_fit     = fit_size(cmd_data, cmd_size);
    res_fit    = fit_size({4'h0, flag_res}, cmd_size);
    step_bytes = {16'h0000, {1'b0, cmd_len, 1'b0} + `CRS_LEN_BASE};  // see RL7
    gpr_hit    = cmd_go && (cmd_idx >= `CRS_IDX_GPR_LO)
                 && ((cmd_op == crs_pkg::OP_WRITE)
                     || ((cmd_op == crs_pkg::OP_FLAGS) && cmd_wr_back));
  end

  // ----------------------------------------------------------------
  // sequencer next state and control
  // ----------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      crs_pkg::ST_IDLE: begin
        if (irq_take) begin
          state_nxt = crs_pkg::ST_PUSH;
        end else if (cmd_go) begin
          unique case (cmd_op)
            crs_pkg::OP_NEAR_CALL,
            crs_pkg::OP_FAR_SUBROUTINE_ENTRY: state_nxt = crs_pkg::ST_PUSH;
            crs_pkg::OP_NEAR_RETURN,
            crs_pkg::OP_FAR_SUBROUTINE_EXIT,
            crs_pkg::OP_INTERRUPT_EXIT_INSTR: state_nxt = crs_pkg::ST_READ;
            default:                          state_nxt = crs_pkg::ST_IDLE;
          endcase
        end
      end
      crs_pkg::ST_PUSH: begin
        if (wcnt_r == 2'h1) begin
          state_nxt = (rcnt_r != 2'h0) ? crs_pkg::ST_READ : crs_pkg::ST_IDLE;
        end
      end
      crs_pkg::ST_READ: state_nxt = crs_pkg::ST_WAIT;
      crs_pkg::ST_WAIT: state_nxt = crs_pkg::ST_TAKE;
      crs_pkg::ST_TAKE: state_nxt = take_last ? crs_pkg::ST_IDLE : crs_pkg::ST_READ;
      default:          state_nxt = crs_pkg::ST_IDLE;
    endcase
  end
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state_r    <= crs_pkg::ST_IDLE;
      op_r       <= crs_pkg::OP_NONE;
      irq_seq_r  <= 1'b0;
      wcnt_r     <= 2'h0;
      rcnt_r     <= 2'h0;
      word0_r    <= 16'h0000;
      word1_r    <= 16'h0000;
      rd0_r      <= 16'h0000;
      vec_addr_r <= 16'h0000;
    end else begin
      state_r <= state_nxt;
      if (irq_take) begin
        op_r       <= crs_pkg::OP_NONE;
        irq_seq_r  <= 1'b1;
        wcnt_r     <= 2'h2;
        rcnt_r     <= 2'h1;
        word0_r    <= prog_cnt_r[15:0];                                   // see RL4
        word1_r    <= {prog_cnt_r[19:16], status_r[11:0]};                // see RL4
        vec_addr_r <= `CRS_VEC_TOP - {10'h000, irq_num, 1'b0};            // see RL2
      end else if (cmd_go) begin
        op_r      <= cmd_op;
        irq_seq_r <= 1'b0;
        unique case (cmd_op)
          crs_pkg::OP_NEAR_CALL: begin
            wcnt_r  <= 2'h1;
            rcnt_r  <= 2'h0;
            word0_r <= prog_cnt_r[15:0];                                  // see RL12
          end
          crs_pkg::OP_FAR_SUBROUTINE_ENTRY: begin
            wcnt_r  <= 2'h2;
            rcnt_r  <= 2'h0;
            word0_r <= {12'h000, prog_cnt_r[19:16]};                      // see RL12
            word1_r <= prog_cnt_r[15:0];
          end
          crs_pkg::OP_NEAR_RETURN: begin
            wcnt_r <= 2'h0;
            rcnt_r <= 2'h1;
          end
          crs_pkg::OP_FAR_SUBROUTINE_EXIT,
          crs_pkg::OP_INTERRUPT_EXIT_INSTR: begin
            wcnt_r <= 2'h0;
            rcnt_r <= 2'h2;
          end
          default: begin
            wcnt_r <= 2'h0;
            rcnt_r <= 2'h0;
          end
        endcase
      end else if (state_r == crs_pkg::ST_PUSH) begin
        wcnt_r  <= wcnt_r - 2'h1;
        word0_r <= word1_r;
      end else if (state_r == crs_pkg::ST_TAKE) begin
        rcnt_r <= rcnt_r - 2'h1;
        rd0_r  <= mem_rdata;
      end
    end
  end

  // ----------------------------------------------------------------
  // handshake outputs and stack memory port
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cmd_ready_r <= 1'b0;
      cmd_ack_r   <= 1'b0;
      irq_ack_r   <= 1'b0;
    end else begin
      cmd_ready_r <= (state_nxt == crs_pkg::ST_IDLE);
      cmd_ack_r   <= cmd_go;
      irq_ack_r   <= irq_take;
    end
  end
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      mem_addr_r  <= 20'h00000;
      mem_wdata_r <= 16'h0000;
      mem_wr_r    <= 1'b0;
      mem_rd_r    <= 1'b0;
    end else begin
      mem_wr_r <= 1'b0;
      mem_rd_r <= 1'b0;
      if (state_r == crs_pkg::ST_PUSH) begin
        mem_wr_r    <= 1'b1;
        mem_addr_r  <= stk_ptr_r - `CRS_STACK_STEP;                      // see RL15
        mem_wdata_r <= word0_r;
      end else if (state_r == crs_pkg::ST_READ) begin
        mem_rd_r   <= 1'b1;
        mem_addr_r <= irq_seq_r ? {4'h0, vec_addr_r} : stk_ptr_r;        // see RL1
      end
    end
  end

  // ----------------------------------------------------------------
  // stack pointer and program counter
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      stk_ptr_r <= `CRS_STACK_RST;
    end else if (cmd_go && (cmd_op == crs_pkg::OP_WRITE) && (cmd_idx == `CRS_IDX_STACK)) begin
      stk_ptr_r <= {wr_fit[19:1], 1'b0};                                 // see RL16
    end else if (state_r == crs_pkg::ST_PUSH) begin
      stk_ptr_r <= stk_ptr_r - `CRS_STACK_STEP;                          // see RL15, RL24
    end else if ((state_r == crs_pkg::ST_READ) && !irq_seq_r) begin
      stk_ptr_r <= stk_ptr_r + `CRS_STACK_STEP;                          // see RL13, RL14, RL15
    end
  end
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      prog_cnt_r <= `CRS_PROG_RST;
    end else if (cmd_go) begin
      unique case (cmd_op)
        crs_pkg::OP_ADVANCE: prog_cnt_r <= prog_cnt_r + step_bytes;  // see RL7
        crs_pkg::OP_WRITE: begin
          if (cmd_idx == `CRS_IDX_PROG) begin
            prog_cnt_r <= {wr_fit[19:1], 1'b0};                          // see RL8, RL11
          end
        end
        crs_pkg::OP_NEAR_JUMP_INSTR,
        crs_pkg::OP_NEAR_CALL: prog_cnt_r <= {4'h0, cmd_data[15:1], 1'b0};  // see RL9
        crs_pkg::OP_FAR_JUMP_INSTR,
        crs_pkg::OP_FAR_SUBROUTINE_ENTRY: prog_cnt_r <= {cmd_data[19:1], 1'b0};  // see RL10
        default: prog_cnt_r <= prog_cnt_r;
      endcase
    end else if (take_last) begin
      if (irq_seq_r) begin
        prog_cnt_r <= {4'h0, mem_rdata[15:1], 1'b0};                     // see RL3
      end else begin
        unique case (op_r)
          crs_pkg::OP_NEAR_RETURN: prog_cnt_r <= {prog_cnt_r[19:16], mem_rdata[15:1], 1'b0};  // see RL14
          crs_pkg::OP_FAR_SUBROUTINE_EXIT: prog_cnt_r <= {mem_rdata[3:0], rd0_r[15:1], 1'b0};  // see RL13
          crs_pkg::OP_INTERRUPT_EXIT_INSTR: prog_cnt_r <= {rd0_r[15:12], mem_rdata[15:1], 1'b0};  // see RL5
          default: prog_cnt_r <= prog_cnt_r;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // status word and power control outputs
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      status_r <= `CRS_STATUS_RST;
    end else if (cmd_go && (cmd_op == crs_pkg::OP_WRITE) && (cmd_idx == `CRS_IDX_STATUS)) begin
      if ((cmd_size == crs_pkg::SZ_WORD) && cmd_reg_mode) begin
        status_r <= cmd_data[15:0] & `CRS_STATUS_MASK;                   // see RL17, RL18, RL23
      end
    end else if (cmd_go && (cmd_op == crs_pkg::OP_FLAGS)) begin
      status_r[`CRS_BIT_CARRY] <= flag_c;                                // see RL20
      status_r[`CRS_BIT_ZERO]  <= flag_z;                                // see RL20
      status_r[`CRS_BIT_NEG]   <= flag_n;                                // see RL20
      status_r[`CRS_BIT_OVFL]  <= flag_v;                                // see RL19
    end else if ((state_r == crs_pkg::ST_PUSH) && irq_seq_r && (wcnt_r == 2'h1)) begin
      status_r[`CRS_BIT_IRQ_EN] <= 1'b0;                                 // see RL24
      status_r[`CRS_BIT_HALT]   <= 1'b0;
    end else if (take_last && !irq_seq_r && (op_r == crs_pkg::OP_INTERRUPT_EXIT_INSTR)) begin
      status_r <= rd0_r & `CRS_STATUS_MASK;                              // see RL5
    end
  end
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cpu_halt_r <= 1'b0;
      osc_stop_r <= 1'b0;
    end else begin
      cpu_halt_r <= status_r[`CRS_BIT_HALT];                             // see RL22
      osc_stop_r <= status_r[`CRS_BIT_OSC_STOP] && !lf_xtal_in_use;      // see RL22
    end
  end

  // ----------------------------------------------------------------
  // working registers and read port
  // ----------------------------------------------------------------
  for (genvar gi = 4; gi < 16; gi++) begin : g_gpr
    always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
        gpr_r[gi] <= `CRS_GPR_RST;
      end else if (gpr_hit && (cmd_idx == 4'(gi))) begin
        gpr_r[gi] <= (cmd_op == crs_pkg::OP_FLAGS) ? res_fit : wr_fit;   // see RL6
      end
    end
  end
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rd_data_r <= 20'h00000;
    end else begin
      unique case (rd_idx)
        `CRS_IDX_PROG:   rd_data_r <= prog_cnt_r;                        // see RL6
        `CRS_IDX_STACK:  rd_data_r <= stk_ptr_r;
        `CRS_IDX_STATUS: rd_data_r <= {4'h0, status_r};
        `CRS_IDX_CONST:  rd_data_r <= 20'h00000;
        default:         rd_data_r <= gpr_r[rd_idx];
      endcase
    end
  end

endmodule

`default_nettype wire

//--- test/crs_core_regs_checker.sv
// assertions on the ports of the core register set
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------
// checker
// ----------------------------------------
module crs_core_regs_checker (
  input wire logic               clk_sys,
  input wire logic               rst,
  input wire crs_pkg::crs_op_e   cmd_op,
  input wire logic        [3:0]  cmd_idx,
  input wire crs_pkg::crs_size_e cmd_size,
  input wire logic        [1:0]  cmd_len,
  input wire logic               irq_req,
  input wire logic               irq_nmi,
  input wire logic               lf_xtal_in_use,
  input wire logic               cmd_ack_r,
  input wire logic               irq_ack_r,
  input wire logic        [19:0] prog_cnt_r,
  input wire logic        [19:0] stk_ptr_r,
  input wire logic        [15:0] status_r,
  input wire logic               mem_wr_r,
  input wire logic               cpu_halt_r,
  input wire logic               osc_stop_r
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);
  sequence two_pushes;
    mem_wr_r ##1 mem_wr_r;
  endsequence
  AST_PC_EVEN: assert property (!prog_cnt_r[0] && !stk_ptr_r[0])
    else $error("odd counter or stack pointer");
  AST_ADVANCE: assert property (cmd_ack_r && $past(cmd_op) == crs_pkg::OP_ADVANCE |->
    prog_cnt_r == $past(prog_cnt_r) + {17'h0, $past(cmd_len), 1'b0} + 20'h2)
    else $error("advance step wrong");
  AST_NEAR_TOP: assert property (cmd_ack_r && $past(cmd_op) inside {crs_pkg::OP_NEAR_JUMP_INSTR,
    crs_pkg::OP_NEAR_CALL} |-> prog_cnt_r[19:16] == 4'h0)
    else $error("near branch kept upper bits");
  AST_NEAR_RET: assert property (cmd_ack_r && $past(cmd_op) == crs_pkg::OP_NEAR_RETURN |=>
    stk_ptr_r == $past(stk_ptr_r) + 20'h2)
    else $error("near return stack step wrong");
  AST_IRQ_GATE: assert property (irq_ack_r |-> $past(irq_req) && ($past(status_r[3]) || $past(irq_nmi)))
    else $error("masked interrupt taken");
  AST_IRQ_PUSH: assert property (irq_ack_r |=> two_pushes)
    else $error("interrupt pushes missing");
  AST_IRQ_SP: assert property (irq_ack_r |-> ##3 stk_ptr_r == $past(stk_ptr_r, 3) - 20'h4)
    else $error("interrupt stack drop wrong");
  AST_SR_PROT: assert property (cmd_ack_r && $past(cmd_op) == crs_pkg::OP_WRITE && $past(cmd_idx) == 4'h2
    && $past(cmd_size) != crs_pkg::SZ_WORD |-> status_r == $past(status_r))
    else $error("status written by non-word write");
  AST_RSVD: assert property (status_r[15:9] == 7'h0)
    else $error("reserved status bits set");
  AST_HALT: assert property ((status_r[4] |=> cpu_halt_r) and (cmd_ack_r |-> !$past(status_r[4])))
    else $error("halt not honoured");
  AST_OSC: assert property (status_r[5] && !lf_xtal_in_use |=> osc_stop_r)
    else $error("oscillator not stopped");
endmodule
bind crs_core_regs crs_core_regs_checker u_chk (.clk_sys, .rst, .cmd_op, .cmd_idx, .cmd_size, .cmd_len,
  .irq_req, .irq_nmi, .lf_xtal_in_use, .cmd_ack_r, .irq_ack_r, .prog_cnt_r, .stk_ptr_r, .status_r,
  .mem_wr_r, .cpu_halt_r, .osc_stop_r);
`default_nettype wire

//--- test/test_crs_core_regs.sv
// self-checking bench for the core register set
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------
// bench
// ----------------------------------------
module test_crs_core_regs;
  logic clk_sys = 1'b0, rst = 1'b1, cmd_valid = 1'b0, cmd_reg_mode = 1'b1, cmd_sub = 1'b0, irq_req = 1'b0;
  logic lf_xtal_in_use = 1'b1, s;
  crs_pkg::crs_op_e   cmd_op = crs_pkg::OP_NONE;
  crs_pkg::crs_size_e cmd_size = crs_pkg::SZ_WORD;
  logic [3:0]  cmd_idx = 4'h0;
  logic [19:0] cmd_data = 20'h0, pc, prog_cnt_r, stk_ptr_r, rd_data_r, mem_addr_r;
  logic [15:0] cmd_opnd_b = 16'h0, mem_rdata = 16'h0, a, b, st, status_r, mem_wdata_r;
  logic [1:0]  cmd_len = 2'h0;
  logic [15:0] mem [0:127];
  logic        cmd_ready_r, cmd_ack_r, irq_ack_r, mem_wr_r, mem_rd_r, cpu_halt_r, osc_stop_r;
  logic [31:0] seed = 32'hd79eae1e;
  int          failures = 0, n_compared = 0, cyc = 0;
  crs_core_regs u_dut (.clk_sys, .rst, .cmd_valid, .cmd_op, .cmd_idx, .cmd_size, .cmd_reg_mode, .cmd_data,
    .cmd_opnd_b, .cmd_sub, .cmd_wr_back(1'b0), .cmd_len, .irq_req, .irq_nmi(1'b0), .irq_num(5'h4),
    .lf_xtal_in_use, .rd_idx(4'h1), .mem_rdata, .cmd_ready_r, .cmd_ack_r, .irq_ack_r, .prog_cnt_r, .stk_ptr_r,
    .status_r, .rd_data_r, .mem_addr_r, .mem_wdata_r, .mem_wr_r, .mem_rd_r, .cpu_halt_r, .osc_stop_r);
  initial forever #5 clk_sys = ~clk_sys;
  // stack memory, inverted data when not read
  always @(posedge clk_sys) begin
    if (mem_wr_r)
      mem[mem_addr_r[7:1]] <= mem_wdata_r;
    mem_rdata <= mem[mem_addr_r[7:1]] ^ {16{~mem_rd_r}};
    cyc++;
    if (cyc == 4000) begin
      failures++;
      wrap_up();
    end
  end
  function automatic logic [31:0] xs(input logic [31:0] v);
    v = v ^ (v << 13);
    v = v ^ (v >> 17);
    return v ^ (v << 5);
  endfunction
  // expected {v, n, z, c}
  function automatic logic [3:0] flg(input logic [15:0] x, input logic [15:0] y, input logic m);
    logic [16:0] r;
    y = m ? ~y : y;
    r = {1'b0, x} + {1'b0, y} + {16'h0, m};
    return {x[15] == y[15] && r[15] != x[15], r[15], r[15:0] == 16'h0, r[16]};
  endfunction
  task automatic chk(input string what, input logic [19:0] seen, input logic [19:0] exp);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wrap_up();
    $display("compared %0d mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic cmd(input crs_pkg::crs_op_e op, input logic [3:0] idx, input crs_pkg::crs_size_e sz,
                     input logic [19:0] d);
    @(posedge clk_sys);
    cmd_valid <= 1'b1;
    cmd_op <= op;
    cmd_idx <= idx;
    cmd_size <= sz;
    cmd_data <= d;
    repeat (20) begin
      @(posedge clk_sys);
      #1;
      if (cmd_ack_r === 1'b1)
        break;
    end
    cmd_valid <= 1'b0;
    wait (cmd_ready_r === 1'b1);
    repeat (3) @(posedge clk_sys);
    #1;
  endtask
  initial begin
    mem[123] = 16'h4321;
    repeat (8) @(posedge clk_sys);
    chk("reset", prog_cnt_r | stk_ptr_r | {4'h0, status_r}, 20'h0);
    rst <= 1'b0;
    cmd(crs_pkg::OP_WRITE, 4'h1, crs_pkg::SZ_ADDR, 20'h00281);
    chk("sp load", stk_ptr_r, 20'h00280);
    irq_req <= 1'b1;
    repeat (6) @(posedge clk_sys);
    irq_req <= 1'b0;
    cmd(crs_pkg::OP_FAR_JUMP_INSTR, 4'h0, crs_pkg::SZ_ADDR, 20'h5a3c7);
    chk("far jump", prog_cnt_r, 20'h5a3c6);
    repeat (4) begin
      seed = xs(seed);
      pc = prog_cnt_r;
      cmd_len <= seed[1:0];
      cmd(crs_pkg::OP_ADVANCE, 4'h0, crs_pkg::SZ_WORD, 20'h0);
      chk("advance", prog_cnt_r, pc + {17'h0, seed[1:0], 1'b0} + 20'h2);
    end
    cmd(crs_pkg::OP_WRITE, 4'h0, crs_pkg::SZ_WORD, 20'h71235);
    chk("word pc", prog_cnt_r, 20'h01234);
    cmd(crs_pkg::OP_FAR_JUMP_INSTR, 4'h0, crs_pkg::SZ_ADDR, 20'h3a000);
    cmd(crs_pkg::OP_FAR_SUBROUTINE_ENTRY, 4'h0, crs_pkg::SZ_ADDR, 20'h52468);
    chk("far call", {prog_cnt_r[15:0] ^ mem[62], stk_ptr_r[3:0]}, 20'h8468c);
    chk("far call high", {prog_cnt_r[19:16], mem[63]}, 20'h50003);
    cmd(crs_pkg::OP_FAR_SUBROUTINE_EXIT, 4'h0, crs_pkg::SZ_ADDR, 20'h0);
    chk("far ret", prog_cnt_r ^ stk_ptr_r, 20'h3a280);
    cmd(crs_pkg::OP_NEAR_CALL, 4'h0, crs_pkg::SZ_WORD, 20'h7abcd);
    chk("near call", prog_cnt_r ^ stk_ptr_r, 20'h0a9b2);
    chk("near push", {4'h0, mem[63]}, 20'h0a000);
    cmd(crs_pkg::OP_NEAR_RETURN, 4'h0, crs_pkg::SZ_WORD, 20'h0);
    chk("near ret", prog_cnt_r ^ stk_ptr_r, 20'h0a280);
    for (int i = 0; i < 8; i++) begin
      seed = xs(seed);
      a = i == 0 ? 16'h7fff : i == 1 ? 16'h8000 : seed[31:16];
      b = i < 2 ? 16'h0001 : i == 2 ? a : seed[15:0];
      s = i == 1 || i == 2 || seed[5];
      cmd_opnd_b <= b;
      cmd_sub <= s;
      cmd(crs_pkg::OP_FLAGS, 4'h4, crs_pkg::SZ_WORD, {4'h0, a});
      chk("flags", {16'h0, status_r[8], status_r[2:0]}, {16'h0, flg(a, b, s)});
    end
    st = status_r;
    cmd(crs_pkg::OP_WRITE, 4'h2, crs_pkg::SZ_ADDR, 20'h00010);
    cmd_reg_mode <= 1'b0;
    cmd(crs_pkg::OP_WRITE, 4'h2, crs_pkg::SZ_WORD, 20'h00010);
    chk("sr guard", {4'h0, status_r}, {4'h0, st});
    cmd_reg_mode <= 1'b1;
    cmd(crs_pkg::OP_WRITE, 4'h2, crs_pkg::SZ_WORD, 20'h0fe28);
    chk("sr write", {3'h0, osc_stop_r, status_r}, 20'h00028);
    lf_xtal_in_use <= 1'b0;
    cmd(crs_pkg::OP_FAR_JUMP_INSTR, 4'h0, crs_pkg::SZ_ADDR, 20'h6b004);
    chk("osc stop", {19'h0, osc_stop_r}, 20'h1);
    @(posedge clk_sys);
    irq_req <= 1'b1;
    #1;
    wait (irq_ack_r === 1'b1);
    irq_req <= 1'b0;
    repeat (10) @(posedge clk_sys);
    chk("irq entry", prog_cnt_r ^ stk_ptr_r, 20'h0415c);
    chk("irq stack", {mem[63] ^ mem[62], status_r[3:0]}, 20'hd02c0);
    cmd(crs_pkg::OP_INTERRUPT_EXIT_INSTR, 4'h0, crs_pkg::SZ_WORD, 20'h0);
    chk("irq exit", prog_cnt_r ^ {4'h0, status_r}, 20'h6b02c);
    chk("read port", rd_data_r, 20'h00280);
    cmd(crs_pkg::OP_WRITE, 4'h2, crs_pkg::SZ_WORD, 20'h00010);
    cmd(crs_pkg::OP_ADVANCE, 4'h0, crs_pkg::SZ_WORD, 20'h0);
    chk("halted", {prog_cnt_r[18:0], cpu_halt_r}, {19'h6b004, 1'b1});
    wrap_up();
  end
endmodule
`default_nettype wire
